// ---- tas_pkg.sv ----
// package: constants, register map and types of the touch acquisition scheduler
package tas_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned TICK_MS = 1;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned ACQ_LIMIT_MS = 250;
	localparam int unsigned ACQ_LIMIT_CYCLES = CLK_HZ / 1000 * ACQ_LIMIT_MS;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int unsigned NSENS = 8;
	localparam int unsigned SIG_W = 12;
	localparam int unsigned POS_W = 8;
	localparam int unsigned INTEG_W = 5;
	localparam logic [POS_W-1:0] SCREEN_MAX = 8'hFF;
	localparam logic [INTEG_W-1:0] NOISE_INTEG_EXTRA = 5'h02;
	localparam logic [3:0] LFSR_SEED = 4'h1;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_IDLE_INT = 8'h04;
	localparam logic [7:0] OFS_ACTIVE_INT = 8'h08;
	localparam logic [7:0] OFS_TIMEOUT = 8'h0C;
	localparam logic [7:0] OFS_THRESH = 8'h10;
	localparam logic [7:0] OFS_INTEG = 8'h14;
	localparam logic [7:0] OFS_NOISE_LIM = 8'h18;
	localparam logic [7:0] OFS_EDGE_BAND = 8'h1C;
	localparam logic [7:0] OFS_CMD = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_TOUCH = 8'h28;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int unsigned CTRL_RUN = 0;
	localparam int unsigned CTRL_SELF = 1;
	localparam int unsigned CTRL_SPREAD = 2;
	localparam int unsigned CTRL_NOISE_HOST = 3;
	localparam int unsigned CTRL_MOIST = 4;
	localparam int unsigned CMD_RECAL = 0;
	localparam int unsigned CMD_TUNE = 1;
	localparam int unsigned ST_ACTIVE = 0;
	localparam int unsigned ST_SIG_ERROR = 1;
	localparam int unsigned ST_NOISE = 2;
	localparam int unsigned ST_MOIST = 3;
	localparam int unsigned ST_TUNING = 4;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [4:0] RST_CTRL = 5'h01;
	localparam logic [15:0] RST_IDLE_INT = 16'h0064;
	localparam logic [15:0] RST_ACTIVE_INT = 16'h0010;
	localparam logic [15:0] RST_TIMEOUT = 16'h01F4;
	localparam logic [SIG_W-1:0] RST_THRESH = 12'h040;
	localparam logic [3:0] RST_INTEG = 4'h4;
	localparam logic [SIG_W-1:0] RST_NOISE_LIM = 12'h200;
	localparam logic [POS_W-1:0] RST_EDGE_BAND = 8'h10;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		PH_STOP = 2'h0,
		PH_BURST = 2'h1,
		PH_SLEEP = 2'h3
	} tas_phase_type;

	typedef struct packed {
		logic [2:0] sensor;
		logic [POS_W-1:0] xpos;
		logic [POS_W-1:0] ypos;
		logic [SIG_W-1:0] mutual;
		logic [SIG_W-1:0] self_sig;
		logic [SIG_W-1:0] noise;
	} tas_sample_type;

	typedef struct packed {
		logic [4:0] ctrl;
		logic [15:0] idle_int;
		logic [15:0] active_int;
		logic [15:0] timeout;
		logic [SIG_W-1:0] thresh;
		logic [3:0] integ;
		logic [SIG_W-1:0] noise_lim;
		logic [POS_W-1:0] edge_band;
	} tas_cfg_type;

endpackage : tas_pkg

// ---- tas_top.sv ----
// module: burst scheduling, detection integrators and touch decisions
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
// Function
// R1: exactly one of two states, active while touched, idle while untouched
// R2: both states repeat a measurement burst followed by a sleep interval
// R3: cycle length is idle or active interval, chosen by current state
// R4: idle interval normally longer than active interval, set by host values
// R5: go idle after no touch for timeout, return active on any touch
// R6: per-sensor counter increments when signal stays above threshold this acquisition
// R7: sensor declared touched only when counter reaches integration limit
// R8: any acquisition without exceeding threshold clears the counter to zero
// R9: flag signal error when whole-sensor acquisition time exceeds 250 ms
// R10: host keeps timing settings such that acquisition limit is never exceeded
// R11: recalibrate all nodes on host recalibrate command
// R12: recalibrate on configuration change and after self tune completes
// R13: recalibrate when calibrated-in moisture is reported removed
// R14: enter noise suppression when host signals a noise source
// R15: start noise suppression when measured noise exceeds limit, adjusting acquisition
// R16: with spread spectrum enabled, change burst frequency every measurement pulse
// R17: with self capacitance enabled, classify using mutual and self data
// R18: prefer mutual data; self only for single touches mutual missed
// R19: while moisture present, detect single touches with self data alone
// R20: suppress touches inside edge band, keep touches toward the centre
module tas_top #(
	parameter int unsigned TICK_CYCLES = tas_pkg::TICK_CYCLES,
	parameter int unsigned ACQ_LIMIT_CYCLES = tas_pkg::ACQ_LIMIT_CYCLES
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic sample_valid,
	input wire tas_pkg::tas_sample_type sample,
	input wire logic meas_pulse,
	input wire logic burst_done,
	input wire logic tune_done,
	input wire logic moisture_found,
	input wire logic moisture_gone,
	output logic burst_start,
	output logic burst_on,
	output logic [3:0] tx_freq_sel,
	output logic calib_req,
	output logic tune_req,
	output logic noise_supp,
	output logic active_mode,
	output logic signal_error_flag,
	output logic [tas_pkg::NSENS-1:0] touch_map
);

	// ----------------------------------------
	// register port
	// ----------------------------------------
	tas_pkg::tas_cfg_type cfg, next_cfg;
	logic [15:0] next_reg_rdata;
	logic next_calib_req, next_tune_req, tuning, next_tuning;
	logic cfg_write, sig_error_set, sig_error_clr;
	logic [tas_pkg::NSENS-1:0] touched;
	logic moist, next_moist;
	logic noise_auto;

	assign cfg_write = reg_wr && (reg_addr <= tas_pkg::OFS_EDGE_BAND);
	// write-one clears, but a fresh overrun in the same cycle wins
	assign sig_error_clr = reg_wr && (reg_addr == tas_pkg::OFS_STATUS)
		&& reg_wdata[tas_pkg::ST_SIG_ERROR];

	always_comb begin
		next_cfg = cfg;
		next_reg_rdata = 16'h0000;
		next_tune_req = 1'b0;
		next_tuning = tuning;
		next_moist = moist;
		next_calib_req = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				tas_pkg::OFS_CTRL: next_cfg.ctrl = reg_wdata[4:0];
				tas_pkg::OFS_IDLE_INT: next_cfg.idle_int = reg_wdata;
				tas_pkg::OFS_ACTIVE_INT: next_cfg.active_int = reg_wdata;
				tas_pkg::OFS_TIMEOUT: next_cfg.timeout = reg_wdata;
				tas_pkg::OFS_THRESH: next_cfg.thresh = reg_wdata[tas_pkg::SIG_W-1:0];
				tas_pkg::OFS_INTEG: next_cfg.integ = reg_wdata[3:0];
				tas_pkg::OFS_NOISE_LIM: next_cfg.noise_lim = reg_wdata[tas_pkg::SIG_W-1:0];
				tas_pkg::OFS_EDGE_BAND: next_cfg.edge_band = reg_wdata[tas_pkg::POS_W-1:0];
				tas_pkg::OFS_CMD: begin
					next_tune_req = reg_wdata[tas_pkg::CMD_TUNE];
					if (reg_wdata[tas_pkg::CMD_TUNE]) begin
						next_tuning = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (reg_wr && (reg_addr == tas_pkg::OFS_CMD) && reg_wdata[tas_pkg::CMD_RECAL]) begin
			next_calib_req = 1'b1; // [R11]
		end
		if (cfg_write) begin
			next_calib_req = 1'b1; // [R12]
		end
		if (tune_done && tuning) begin
			next_tuning = 1'b0;
			next_calib_req = 1'b1; // [R12]
		end
		// moisture tracking only counts while compensation is on
		if (!cfg.ctrl[tas_pkg::CTRL_MOIST]) begin
			next_moist = 1'b0;
		end else if (moisture_found) begin
			next_moist = 1'b1;
		end else if (moisture_gone && moist) begin
			next_moist = 1'b0;
			next_calib_req = 1'b1; // [R13]
		end
		if (reg_rd) begin
			case (reg_addr)
				tas_pkg::OFS_CTRL: next_reg_rdata = {11'h000, cfg.ctrl};
				tas_pkg::OFS_IDLE_INT: next_reg_rdata = cfg.idle_int;
				tas_pkg::OFS_ACTIVE_INT: next_reg_rdata = cfg.active_int;
				tas_pkg::OFS_TIMEOUT: next_reg_rdata = cfg.timeout;
				tas_pkg::OFS_THRESH: next_reg_rdata = {4'h0, cfg.thresh};
				tas_pkg::OFS_INTEG: next_reg_rdata = {12'h000, cfg.integ};
				tas_pkg::OFS_NOISE_LIM: next_reg_rdata = {4'h0, cfg.noise_lim};
				tas_pkg::OFS_EDGE_BAND: next_reg_rdata = {8'h00, cfg.edge_band};
				tas_pkg::OFS_STATUS: next_reg_rdata = {11'h000, tuning, moist, noise_supp,
					signal_error_flag, active_mode};
				tas_pkg::OFS_TOUCH: next_reg_rdata = {8'h00, touch_map};
				default: next_reg_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cfg <= '{ctrl: tas_pkg::RST_CTRL, idle_int: tas_pkg::RST_IDLE_INT,
				active_int: tas_pkg::RST_ACTIVE_INT, timeout: tas_pkg::RST_TIMEOUT,
				thresh: tas_pkg::RST_THRESH, integ: tas_pkg::RST_INTEG,
				noise_lim: tas_pkg::RST_NOISE_LIM, edge_band: tas_pkg::RST_EDGE_BAND};
			reg_rdata <= 16'h0000;
			calib_req <= 1'b0;
			tune_req <= 1'b0;
			tuning <= 1'b0;
			moist <= 1'b0;
		end else begin
			cfg <= next_cfg;
			reg_rdata <= next_reg_rdata;
			calib_req <= next_calib_req;
			tune_req <= next_tune_req;
			tuning <= next_tuning;
			moist <= next_moist;
		end
	end

	// ----------------------------------------
	// burst scheduler and mode
	// ----------------------------------------
	tas_pkg::tas_phase_type phase, next_phase;
	logic [31:0] tick_cnt, next_tick_cnt;
	logic tick;
	logic [15:0] cyc_ms, next_cyc_ms;
	logic [15:0] idle_ms, next_idle_ms;
	logic [31:0] acq_cnt, next_acq_cnt;
	logic [15:0] interval;
	logic next_burst_start, next_burst_on, next_active, next_signal_error_flag;
	logic [3:0] next_freq;
	logic noise_seen, next_noise_seen, next_noise_auto, next_noise_supp;
	logic noisy;

	assign tick = (tick_cnt == TICK_CYCLES - 1);
	// idle normally configured slower, giving fewer bursts untouched
	assign interval = active_mode ? cfg.active_int : cfg.idle_int; // [R3] [R4]
	assign noisy = sample_valid && (sample.noise > cfg.noise_lim);
	// a burst of exactly the limit is allowed; only a longer one is an error
	assign sig_error_set = (phase == tas_pkg::PH_BURST) && (acq_cnt == ACQ_LIMIT_CYCLES);

	always_comb begin
		next_phase = phase;
		next_tick_cnt = tick ? 32'h00000000 : tick_cnt + 32'h00000001;
		next_cyc_ms = (tick && cyc_ms != 16'hFFFF) ? cyc_ms + 16'h0001 : cyc_ms;
		next_idle_ms = idle_ms;
		next_acq_cnt = acq_cnt;
		next_burst_start = 1'b0;
		next_burst_on = burst_on;
		next_active = active_mode;
		next_signal_error_flag = signal_error_flag;
		next_freq = tx_freq_sel;
		next_noise_seen = noise_seen | noisy;
		next_noise_auto = noise_auto | noisy; // [R15]
		case (phase)
			tas_pkg::PH_STOP: begin
				if (cfg.ctrl[tas_pkg::CTRL_RUN]) begin
					next_phase = tas_pkg::PH_BURST;
					next_burst_start = 1'b1;
					next_burst_on = 1'b1;
					next_cyc_ms = 16'h0000;
					next_acq_cnt = 32'h00000000;
				end
			end
			tas_pkg::PH_BURST: begin
				// counter holds at the limit so the flag is set again every cycle until the burst ends
				if (acq_cnt != ACQ_LIMIT_CYCLES) begin
					next_acq_cnt = acq_cnt + 32'h00000001;
				end
				if (burst_done) begin
					next_phase = tas_pkg::PH_SLEEP; // [R2]
					next_burst_on = 1'b0;
					next_noise_seen = 1'b0;
					// a clean burst ends automatic suppression
					next_noise_auto = noise_seen | noisy;
				end
			end
			tas_pkg::PH_SLEEP: begin
				if (!cfg.ctrl[tas_pkg::CTRL_RUN]) begin
					next_phase = tas_pkg::PH_STOP;
				end else if (cyc_ms >= interval) begin
					next_phase = tas_pkg::PH_BURST; // [R2] [R3]
					next_burst_start = 1'b1;
					next_burst_on = 1'b1;
					next_cyc_ms = 16'h0000;
					next_acq_cnt = 32'h00000000;
				end
			end
			default: begin
				next_phase = tas_pkg::PH_STOP;
				next_burst_on = 1'b0;
			end
		endcase
		if (sig_error_set) begin
			next_signal_error_flag = 1'b1; // [R9]
		end else if (sig_error_clr) begin
			next_signal_error_flag = 1'b0;
		end
		// single state bit: active and idle exclusive by construction
		if (|touched) begin
			next_active = 1'b1; // [R1] [R5]
			next_idle_ms = 16'h0000;
		end else if (active_mode && tick) begin
			next_idle_ms = idle_ms + 16'h0001;
			if (idle_ms + 16'h0001 >= cfg.timeout) begin
				next_active = 1'b0; // [R5]
				next_idle_ms = 16'h0000;
			end
		end
		if (!cfg.ctrl[tas_pkg::CTRL_SPREAD]) begin
			next_freq = tas_pkg::LFSR_SEED;
		end else if (meas_pulse) begin
			next_freq = {tx_freq_sel[2:0], tx_freq_sel[3] ^ tx_freq_sel[2]}; // [R16]
		end
		next_noise_supp = cfg.ctrl[tas_pkg::CTRL_NOISE_HOST] | next_noise_auto; // [R14] [R15]
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			phase <= tas_pkg::PH_STOP;
			tick_cnt <= 32'h00000000;
			cyc_ms <= 16'h0000;
			idle_ms <= 16'h0000;
			acq_cnt <= 32'h00000000;
			burst_start <= 1'b0;
			burst_on <= 1'b0;
			active_mode <= 1'b0;
			signal_error_flag <= 1'b0;
			tx_freq_sel <= tas_pkg::LFSR_SEED;
			noise_seen <= 1'b0;
			noise_auto <= 1'b0;
			noise_supp <= 1'b0;
		end else begin
			phase <= next_phase;
			tick_cnt <= next_tick_cnt;
			cyc_ms <= next_cyc_ms;
			idle_ms <= next_idle_ms;
			acq_cnt <= next_acq_cnt;
			burst_start <= next_burst_start;
			burst_on <= next_burst_on;
			active_mode <= next_active;
			signal_error_flag <= next_signal_error_flag;
			tx_freq_sel <= next_freq;
			noise_seen <= next_noise_seen;
			noise_auto <= next_noise_auto;
			noise_supp <= next_noise_supp;
		end
	end

	// ----------------------------------------
	// touch classification and integrators
	// ----------------------------------------
	logic mut_hit, self_hit, others, hit, in_band;
	logic [tas_pkg::INTEG_W-1:0] lim;

	// noise suppression lengthens confirmation instead of raising thresholds
	assign lim = {1'b0, cfg.integ} + (noise_supp ? tas_pkg::NOISE_INTEG_EXTRA : 5'h00); // [R15]
	assign mut_hit = sample.mutual > cfg.thresh; // [R6]
	assign self_hit = sample.self_sig > cfg.thresh;
	assign others = |(touched & ~(tas_pkg::NSENS'(1) << sample.sensor));
	assign in_band = (sample.xpos < cfg.edge_band) || (sample.ypos < cfg.edge_band)
		|| (sample.xpos > tas_pkg::SCREEN_MAX - cfg.edge_band)
		|| (sample.ypos > tas_pkg::SCREEN_MAX - cfg.edge_band);

	always_comb begin
		if (moist) begin
			hit = self_hit && !others; // [R19]
		end else if (cfg.ctrl[tas_pkg::CTRL_SELF]) begin
			hit = mut_hit || (self_hit && !others); // [R17] [R18]
		end else begin
			hit = mut_hit; // [R18]
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < tas_pkg::NSENS; gi++) begin : g_sens
			logic [tas_pkg::INTEG_W-1:0] integ, next_integ;
			logic grip, next_grip, next_touch;
			logic mine;

			assign mine = sample_valid && (sample.sensor == 3'(gi));
			assign touched[gi] = (integ >= lim); // [R7]

			always_comb begin
				next_integ = integ;
				next_grip = grip;
				if (calib_req) begin
					next_integ = '0; // new baseline restarts confirmation
				end else if (mine) begin
					next_grip = in_band;
					if (!hit) begin
						next_integ = '0; // [R8]
					end else if (integ < lim) begin
						next_integ = integ + 5'h01; // [R6]
					end
				end
				next_touch = (next_integ >= lim) && !next_grip; // [R7] [R20]
			end

			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					integ <= '0;
					grip <= 1'b0;
					touch_map[gi] <= 1'b0;
				end else begin
					integ <= next_integ;
					grip <= next_grip;
					touch_map[gi] <= next_touch;
				end
			end
		end
	endgenerate

endmodule : tas_top

// ---- tas_chk_sva.sv ----
// checker: port properties of the touch acquisition scheduler
`timescale 1ns/1ps
module tas_chk #(
	parameter int unsigned ACQ_LIMIT_CYCLES = 200
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic sample_valid,
	input wire tas_pkg::tas_sample_type sample,
	input wire logic meas_pulse,
	input wire logic burst_done,
	input wire logic burst_start,
	input wire logic burst_on,
	input wire logic [3:0] tx_freq_sel,
	input wire logic calib_req,
	input wire logic noise_supp,
	input wire logic active_mode,
	input wire logic signal_error_flag,
	input wire logic [tas_pkg::NSENS-1:0] touch_map
);
	// ----------------------------------------
	// shadow of host settings, burst length
	// ----------------------------------------
	logic [4:0] ctrl, next_ctrl;
	logic [11:0] nlim, next_nlim;
	logic [31:0] bcnt, next_bcnt;
	always_comb begin
		next_ctrl = ctrl;
		next_nlim = nlim;
		if (reg_wr && reg_addr == tas_pkg::OFS_CTRL) next_ctrl = reg_wdata[4:0];
		if (reg_wr && reg_addr == tas_pkg::OFS_NOISE_LIM) next_nlim = reg_wdata[11:0];
		next_bcnt = burst_on ? bcnt + 32'h1 : 32'h0;
	end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctrl <= tas_pkg::RST_CTRL;
			nlim <= tas_pkg::RST_NOISE_LIM;
			bcnt <= 32'h0;
		end else begin
			ctrl <= next_ctrl;
			nlim <= next_nlim;
			bcnt <= next_bcnt;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	burst_rise_a: assert property ($rose(burst_on) |-> burst_start)
		else $error("burst_on rose without burst_start");
	burst_end_a: assert property (burst_on && burst_done |=> !burst_on)
		else $error("burst_on held after burst_done");
	active_set_a: assert property (|touch_map |=> active_mode)
		else $error("touch without active mode");
	// slack of three cycles: the flag registers one cycle after the limit count
	error_set_a: assert property (burst_on && bcnt == ACQ_LIMIT_CYCLES
		|-> ##[0:3] signal_error_flag)
		else $error("long burst without error flag");
	error_hold_a: assert property (signal_error_flag && !(reg_wr && reg_wdata[1] &&
		reg_addr == tas_pkg::OFS_STATUS) |=> signal_error_flag)
		else $error("error flag dropped without clear");
	recal_cmd_a: assert property (reg_wr && reg_addr == tas_pkg::OFS_CMD && reg_wdata[0]
		|=> calib_req)
		else $error("recal command without calib_req");
	cfg_recal_a: assert property (reg_wr && reg_addr <= tas_pkg::OFS_EDGE_BAND &&
		reg_addr[1:0] == 2'h0 |=> calib_req)
		else $error("config write without calib_req");
	low_clear_a: assert property (sample_valid && sample.mutual == 12'h000 &&
		sample.self_sig == 12'h000 |=> !touch_map[$past(sample.sensor)])
		else $error("low sample left touch set");
	host_noise_a: assert property (ctrl[3] && $past(ctrl[3]) |-> noise_supp)
		else $error("host noise bit without suppression");
	auto_noise_a: assert property (sample_valid && sample.noise > nlim |=> noise_supp)
		else $error("noisy sample without suppression");
	spread_step_a: assert property (ctrl[2] && meas_pulse |=> tx_freq_sel != $past(tx_freq_sel))
		else $error("burst frequency unchanged on pulse");
	burst_seen_c: cover property (burst_start);
	error_seen_c: cover property ($rose(signal_error_flag));
	touch_seen_c: cover property ($rose(touch_map[0]));
endmodule : tas_chk
bind tas_top tas_chk #(.ACQ_LIMIT_CYCLES(ACQ_LIMIT_CYCLES)) chk_u (.clk_sys(clk_sys),
	.nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.sample_valid(sample_valid), .sample(sample), .meas_pulse(meas_pulse),
	.burst_done(burst_done), .burst_start(burst_start), .burst_on(burst_on),
	.tx_freq_sel(tx_freq_sel), .calib_req(calib_req), .noise_supp(noise_supp),
	.active_mode(active_mode), .signal_error_flag(signal_error_flag), .touch_map(touch_map));

// ---- tas_front_model.sv ----
// front-end model: measurement bursts, one result per burst, tune completion
`timescale 1ns/1ps
module tas_front_model (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic burst_start,
	input wire logic tune_req,
	input wire logic [15:0] burst_len,
	input wire tas_pkg::tas_sample_type smp,
	output logic sample_valid,
	output tas_pkg::tas_sample_type sample,
	output logic meas_pulse,
	output logic burst_done,
	output logic tune_done
);
	logic busy;
	logic [15:0] cnt;
	logic [2:0] tcnt;
	assign sample_valid = busy && cnt == 16'h0002;
	// released lines carry no stale value
	assign sample = sample_valid ? smp : ~smp;
	assign meas_pulse = busy && cnt[0];
	// bench keeps burst_len short except in the overlong case
	assign burst_done = busy && cnt >= burst_len;
	assign tune_done = tcnt == 3'h4;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			busy <= 1'b0;
			cnt <= 16'h0000;
			tcnt <= 3'h0;
		end else begin
			busy <= burst_start || (busy && !burst_done);
			cnt <= burst_start ? 16'h0000 : cnt + 16'h0001;
			tcnt <= tune_req ? 3'h1 : (tcnt != 3'h0 ? tcnt + 3'h1 : 3'h0);
		end
	end
endmodule : tas_front_model

// ---- tb_top.sv ----
// testbench: scheduler and touch decisions against the front-end model
`timescale 1ns/1ps
module tb_top;
	typedef struct {
		logic [15:0] ctrl;
		logic [11:0] m;
		logic [11:0] s;
		logic [7:0] x;
		logic [7:0] y;
		int n;
		logic [15:0] e;
	} tas_row_type;
	logic clk_sys = 1'b0;
	logic nrst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic moisture_found = 1'b0;
	logic moisture_gone = 1'b0;
	logic [15:0] burst_len = 16'h0006;
	logic [15:0] reg_rdata, v;
	logic sample_valid, meas_pulse, burst_done, tune_done, burst_start, burst_on;
	logic calib_req, tune_req, noise_supp, active_mode, signal_error_flag;
	logic [3:0] tx_freq_sel;
	logic [7:0] touch_map;
	tas_pkg::tas_sample_type sample;
	tas_pkg::tas_sample_type smp = '0;
	int n_fail = 0;
	int check_count = 0;
	int k;
	tas_row_type rows [9] = '{
		'{16'h0001, 12'h050, 12'h000, 8'h80, 8'h80, 3, 16'h0000},
		'{16'h0001, 12'h050, 12'h000, 8'h80, 8'h80, 4, 16'h0001},
		'{16'h0001, 12'h040, 12'h000, 8'h80, 8'h80, 4, 16'h0000},
		'{16'h0001, 12'h030, 12'h050, 8'h80, 8'h80, 4, 16'h0000},
		'{16'h0003, 12'h030, 12'h050, 8'h80, 8'h80, 4, 16'h0001},
		'{16'h0001, 12'h050, 12'h000, 8'h0F, 8'h80, 4, 16'h0000},
		'{16'h0001, 12'h050, 12'h000, 8'h10, 8'h80, 4, 16'h0001},
		'{16'h0001, 12'h050, 12'h000, 8'h80, 8'hF0, 4, 16'h0000},
		'{16'h0001, 12'h050, 12'h000, 8'h80, 8'hEF, 4, 16'h0001}};
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	tas_top #(.TICK_CYCLES(10), .ACQ_LIMIT_CYCLES(200)) dut_u (.clk_sys(clk_sys), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample(sample),
		.meas_pulse(meas_pulse), .burst_done(burst_done), .tune_done(tune_done),
		.moisture_found(moisture_found), .moisture_gone(moisture_gone),
		.burst_start(burst_start), .burst_on(burst_on), .tx_freq_sel(tx_freq_sel),
		.calib_req(calib_req), .tune_req(tune_req), .noise_supp(noise_supp),
		.active_mode(active_mode), .signal_error_flag(signal_error_flag), .touch_map(touch_map));
	tas_front_model fm_u (.clk_sys(clk_sys), .nrst(nrst), .burst_start(burst_start),
		.tune_req(tune_req), .burst_len(burst_len), .smp(smp), .sample_valid(sample_valid),
		.sample(sample), .meas_pulse(meas_pulse), .burst_done(burst_done), .tune_done(tune_done));
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test
	task automatic tmo(input int lim);
		if (k >= lim) begin
			n_fail++;
			$display("BAD wait expected event seen timeout");
			finish_test();
		end
	endtask : tmo
	// one clock, then settle past the edge before looking
	task automatic step();
		@(posedge clk_sys);
		#1;
	endtask : step
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : rd
	// waits for n front-end results, then lets the decision land
	task automatic smps(input int n);
		for (int i = 0; i < n; i++) begin
			for (k = 0; k < 2000; k++) begin
				step();
				if (sample_valid === 1'b1) break;
			end
			tmo(2000);
		end
		repeat (2) @(posedge clk_sys);
		#1;
	endtask : smps
	initial begin
		nrst <= 1'b0;
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		#1;
		chk("tx reset", 16'h0001, 16'(tx_freq_sel));
		rd(8'h04);
		chk("idle reset", tas_pkg::RST_IDLE_INT, v);
		step();
		chk("rdata drop", 16'h0000, reg_rdata);
		rd(8'h40);
		chk("unmapped", 16'h0000, v);
		wr(8'h04, 16'h0020);
		wr(8'h08, 16'h0008);
		wr(8'h0C, 16'h0010);
		foreach (rows[i]) begin
			smp <= '{3'h0, rows[i].x, rows[i].y, rows[i].m, rows[i].s, 12'h000};
			wr(8'h00, rows[i].ctrl);
			smps(rows[i].n);
			chk("touch row", rows[i].e, 16'(touch_map[0]));
		end
		smp.mutual <= 12'h000;
		smps(1);
		chk("touch cleared", 16'h0000, 16'(touch_map[0]));
		for (k = 0; k < 3000 && active_mode !== 1'b0; k++) step();
		tmo(3000);
		chk("idle mode", 16'h0000, 16'(active_mode));
		for (k = 0; k < 3000 && burst_start !== 1'b1; k++) step();
		tmo(3000);
		step();
		for (k = 1; k < 3000 && burst_start !== 1'b1; k++) step();
		tmo(3000);
		chk("idle gap", 16'h0020, 16'((k + 5) / 10));
		burst_len <= 16'h00FA;
		for (k = 0; k < 3000 && signal_error_flag !== 1'b1; k++) step();
		tmo(3000);
		burst_len <= 16'h0006;
		rd(8'h24);
		chk("status error", 16'h0002, v & 16'h0002);
		wr(8'h24, 16'h0002);
		chk("error cleared", 16'h0000, 16'(signal_error_flag));
		wr(8'h00, 16'h0009);
		@(posedge clk_sys);
		#1;
		chk("host noise", 16'h0001, 16'(noise_supp));
		smp <= '{3'h0, 8'h80, 8'h80, 12'h050, 12'h000, 12'h201};
		wr(8'h00, 16'h0001);
		smps(4);
		chk("auto noise", 16'h0001, 16'(noise_supp));
		chk("noisy limit", 16'h0000, 16'(touch_map[0]));
		smps(2);
		chk("noisy touch", 16'h0001, 16'(touch_map[0]));
		wr(8'h20, 16'h0001);
		chk("recal pulse", 16'h0001, 16'(calib_req));
		repeat (2) @(posedge clk_sys);
		#1;
		chk("recal clears", 16'h0000, 16'(touch_map[0]));
		wr(8'h10, 16'h0040);
		chk("config recal", 16'h0001, 16'(calib_req));
		wr(8'h20, 16'h0002);
		chk("tune pulse", 16'h0001, 16'(tune_req));
		for (k = 0; k < 50 && calib_req !== 1'b1; k++) step();
		tmo(50);
		chk("tune recal", 16'h0001, 16'(calib_req));
		smp <= '{3'h0, 8'h80, 8'h80, 12'h050, 12'h000, 12'h000};
		wr(8'h00, 16'h0013);
		moisture_found <= 1'b1;
		@(posedge clk_sys);
		moisture_found <= 1'b0;
		smps(4);
		chk("moist mutual", 16'h0000, 16'(touch_map[0]));
		rd(8'h24);
		chk("moist flag", 16'h0008, v & 16'h0008);
		moisture_gone <= 1'b1;
		@(posedge clk_sys);
		moisture_gone <= 1'b0;
		#1;
		chk("moist recal", 16'h0001, 16'(calib_req));
		wr(8'h00, 16'h0001);
		smps(1);
		chk("fixed freq", 16'h0001, 16'(tx_freq_sel));
		wr(8'h00, 16'h0005);
		smps(1);
		chk("spread freq", 16'h0001, 16'(tx_freq_sel != 4'h1));
		finish_test();
	end
endmodule : tb_top
